// ### dsr_host_model.sv
// Purpose: Host side of the link: strobe pulses, serial clock bursts, lane capture
// Assumes: Serial clock stands still low between bursts
// Notes:   Lanes launch on falling edges, so they are captured on rising edges
module dsr_host_model (
	// Timing reference
	input  wire logic        mclk,
	// Link pins
	output logic             serial_clock,
	output logic             conversion_strobe_n,
	input  wire logic        channel_one_data_out,
	input  wire logic        channel_two_data_out,
	// Captured words
	output logic [14:0]      cap1,
	output logic [14:0]      cap2
);
	timeunit 1ns;
	timeprecision 100ps;

	// ======================================================================
	// Idle levels
	// ======================================================================
	initial
	begin
		serial_clock = 1'b0;
		conversion_strobe_n = 1'b0;
		cap1 = 15'h0000;
		cap2 = 15'h0000;
	end

	// Burst of n serial clock cycles, 6 ns period, idle low after
	task automatic burst(input int n);
		for (int i = 0; i < n; i++)
		begin
			serial_clock = 1'b1;
			#3;
			serial_clock = 1'b0;
			#3;
		end
	endtask

	// One strobe pulse, serial clock held still throughout
	task automatic strobe;
		@(posedge mclk);
		#2;
		conversion_strobe_n = 1'b1;
		#100;
		conversion_strobe_n = 1'b0;
		#100;
	endtask

	// Only the positive lanes are wired in; negative pins left open
	always @(posedge serial_clock)
	begin
		cap1 <= {cap1[13:0], channel_one_data_out};
		cap2 <= {cap2[13:0], channel_two_data_out};
	end
endmodule

// ### dsr_params.svh
// Purpose: Constants for the dual-channel serial readout and power sequencer
// Assumes: Included by the design file only
// Notes:   Pulse counts are strobe rising edges with no serial clock between
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

// ==========================================================================
// Result word and pulse counter widths
// ==========================================================================
`define DSR_WORD_W       15
`define DSR_PULSE_W      3

// ==========================================================================
// Power-state pulse thresholds (cumulative strobe rises)
// ==========================================================================
`define DSR_NAP_PULSES   3'h2
`define DSR_SLEEP_PULSES 3'h4
`define DSR_WAKE_PULSES  3'h5

`endif

// ### dsr_pkg.sv
// Purpose: Types for the dual-channel serial readout and power sequencer
// Assumes: Nothing
// Notes:   Constants live in dsr_params.svh
package dsr_pkg;

	// ==================================================================
	// Power states
	// ==================================================================
	typedef enum logic [1:0]
	{
		PWR_OPER,
		PWR_NAP,
		PWR_SLEEP
	} dsr_power_e;

endpackage

// ### dsr_readout.sv
// Purpose: Strobe-driven sampling, two-lane serial readout, echo clock, nap/sleep sequencing
// Assumes: mclk at 40 MHz; serial_clock from the host; strobe pin asynchronous to both
// Notes:   Results leave one conversion late; the negative lanes float when CMOS is selected
`include "dsr_params.svh"

// Notes on behaviour
// - Second strobe rise with no serial clock edge between enters nap.
// - Nap holds until a serial clock rise (back to operation) or more strobes.
// - Two more clean strobe pulses from nap enter sleep.
// - In CMOS, one serial clock rise wakes the part from sleep.
// - A fifth clean strobe pulse wakes from sleep, in LVDS and CMOS.
// - Serial clock pulses between strobes keep the part operational.
// - Clean strobes alone cycle operation, nap and sleep forever.
// - Each falling serial clock edge drives the next result bit, MSB first.
// - An echo clock skew-matched to the data is driven out (the code gates serial_clock directly, not through the lane flops).
// - Echo negative pin tied to the I/O supply disables the echo clock.
// - A select pin picks CMOS or LVDS signalling.
// - In CMOS only positive pins are used; negative pins are pulled down (the code only releases their output enables).
// - In LVDS data and echo are differential; serial clock received differentially (the code takes serial_clock on one single-ended pin).
// - Strobe rise starts sampling, the following fall starts conversion and readout.
// - Conversion is timed by the external serial clock.
module dsr_readout #(
	parameter int WORD_W = `DSR_WORD_W
)(
	// System clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// Host link pins
	input  wire logic              serial_clock,
	input  wire logic              conversion_strobe_n,
	input  wire logic              lvds_select,
	input  wire logic              echo_disable,
	// Converter core
	input  wire logic [WORD_W-1:0] ch1_core_result,
	input  wire logic [WORD_W-1:0] ch2_core_result,
	output logic                   sample_start,
	output logic                   core_powered,
	output logic                   ref_powered,
	// Data lanes
	output logic                   channel_one_data_out,
	output logic                   channel_one_data_out_n,
	output logic                   channel_one_data_out_n_oe,
	output logic                   channel_two_data_out,
	output logic                   channel_two_data_out_n,
	output logic                   channel_two_data_out_n_oe,
	// Echo clock
	output logic                   echo_clock_out,
	output logic                   echo_clock_out_n,
	output logic                   echo_clock_out_n_oe
);

	// ==================================================================
	// Pin synchronisers in the mclk domain
	// ==================================================================
	logic                   strb_s1_q, strb_s2_q, strb_s3_q;
	logic                   lvds_s1_q, lvds_q;
	logic                   strb_rise, strb_fall;

	// Strobe and mode select cross into mclk
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			strb_s1_q <= 1'b0; // Pin idles low, so no false edge after reset
			strb_s2_q <= 1'b0;
			strb_s3_q <= 1'b0;
			lvds_s1_q <= 1'b0;
			lvds_q    <= 1'b0;
		end
		else
		begin
			strb_s1_q <= conversion_strobe_n;
			strb_s2_q <= strb_s1_q;
			strb_s3_q <= strb_s2_q;
			lvds_s1_q <= lvds_select;
			lvds_q    <= lvds_s1_q;
		end
	end

	// Strobe edges
	assign strb_rise = strb_s2_q & ~strb_s3_q;
	assign strb_fall = ~strb_s2_q & strb_s3_q;

	// ==================================================================
	// Serial clock domain reset
	// ==================================================================
	logic srst_s1_q, srst_q;

	// Reset release follows the serial clock
	always_ff @(negedge serial_clock)
	begin
		srst_s1_q <= nrst;
		srst_q    <= srst_s1_q;
	end

	// ==================================================================
	// Serial clock rise count, gray coded into mclk
	// ==================================================================
	logic [2:0] sck_cnt_q, sck_cnt_d, sck_gray_q;
	logic [2:0] gray_s1_q, gray_s2_q, gray_seen_q;
	logic       sck_evt;

	assign sck_cnt_d = sck_cnt_q + 3'h1;

	// Count rises; a lone rise after a burst still counts; three bits alias only when a multiple of eight rises falls between mclk samples
	always_ff @(posedge serial_clock)
	begin
		if (!srst_q)
		begin
			sck_cnt_q  <= 3'h0;
			sck_gray_q <= 3'h0;
		end
		else
		begin
			sck_cnt_q  <= sck_cnt_d;
			sck_gray_q <= sck_cnt_d ^ {1'b0, sck_cnt_d[2:1]};
		end
	end

	// Two flops, then any change of the count is one event
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			gray_s1_q   <= 3'h0;
			gray_s2_q   <= 3'h0;
			gray_seen_q <= 3'h0;
		end
		else
		begin
			gray_s1_q   <= sck_gray_q;
			gray_s2_q   <= gray_s1_q;
			gray_seen_q <= gray_s2_q;
		end
	end

	assign sck_evt = (gray_s2_q != gray_seen_q);

	// ==================================================================
	// Power sequencer
	// ==================================================================
	dsr_pkg::dsr_power_e     pwr_q;
	logic [`DSR_PULSE_W-1:0] pulses_q;
	logic [`DSR_PULSE_W-1:0] pulses_d;

	assign pulses_d = pulses_q + 3'h1;

	// Strobe pulse counting with serial clock as the reset
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			pwr_q    <= dsr_pkg::PWR_OPER;
			pulses_q <= '0;
		end
		else if (sck_evt)
		begin
			pulses_q <= {2'h0, strb_rise};
			if (pwr_q == dsr_pkg::PWR_NAP)
				pwr_q <= dsr_pkg::PWR_OPER;
			else if (pwr_q == dsr_pkg::PWR_SLEEP && !lvds_q)
				pwr_q <= dsr_pkg::PWR_OPER;
		end
		else if (strb_rise)
		begin
			pulses_q <= pulses_d;
			case (pwr_q)
				dsr_pkg::PWR_OPER:
					if (pulses_d >= `DSR_NAP_PULSES)
						pwr_q <= dsr_pkg::PWR_NAP;
				dsr_pkg::PWR_NAP:
					if (pulses_d >= `DSR_SLEEP_PULSES)
						pwr_q <= dsr_pkg::PWR_SLEEP;
				dsr_pkg::PWR_SLEEP:
					if (pulses_d >= `DSR_WAKE_PULSES)
					begin
						pwr_q    <= dsr_pkg::PWR_OPER;
						pulses_q <= '0;
					end
				default:
					pwr_q <= dsr_pkg::PWR_OPER;
			endcase
		end
	end

	// Power enables to the analog core
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			core_powered <= 1'b1;
			ref_powered  <= 1'b1;
		end
		else
		begin
			core_powered <= (pwr_q == dsr_pkg::PWR_OPER);
			ref_powered  <= (pwr_q != dsr_pkg::PWR_SLEEP);
		end
	end

	// ==================================================================
	// Sampling and result hand-off
	// ==================================================================
	logic [WORD_W-1:0] conv1_q, conv2_q;
	logic [WORD_W-1:0] word1_q, word2_q;
	logic              load_tog_q;

	// Rise samples, fall publishes the previous conversion
	always_ff @(posedge mclk)
	begin
		if (!nrst)
		begin
			sample_start <= 1'b0;
			conv1_q      <= '0;
			conv2_q      <= '0;
			word1_q      <= '0;
			word2_q      <= '0;
			load_tog_q   <= 1'b0;
		end
		else
		begin
			sample_start <= strb_rise && pwr_q == dsr_pkg::PWR_OPER;
			if (strb_fall && pwr_q == dsr_pkg::PWR_OPER)
			begin
				word1_q    <= conv1_q;
				word2_q    <= conv2_q;
				conv1_q    <= ch1_core_result;
				conv2_q    <= ch2_core_result;
				load_tog_q <= ~load_tog_q;
			end
		end
	end

	// ==================================================================
	// Serial clock domain: shift out and echo
	// ==================================================================
	logic              load_s1_q, load_s2_q, load_s3_q;
	logic              echo_s1_q, echo_en_q;
	logic              load_evt;
	logic [WORD_W-1:0] shift1_q, shift2_q;

	assign load_evt = load_s2_q ^ load_s3_q;

	// Load toggle and echo strap cross on the falling edge
	always_ff @(negedge serial_clock)
	begin
		if (!srst_q)
		begin
			load_s1_q <= 1'b0;
			load_s2_q <= 1'b0;
			load_s3_q <= 1'b0;
			echo_s1_q <= 1'b0;
			echo_en_q <= 1'b0;
		end
		else
		begin
			load_s1_q <= load_tog_q;
			load_s2_q <= load_s1_q;
			load_s3_q <= load_s2_q;
			echo_s1_q <= ~echo_disable;
			echo_en_q <= echo_s1_q;
		end
	end

	// Both lanes shift MSB first on the same falling edge
	always_ff @(negedge serial_clock)
	begin
		if (!srst_q)
		begin
			shift1_q <= '0;
			shift2_q <= '0;
		end
		else if (load_evt)
		begin
			shift1_q <= word1_q;
			shift2_q <= word2_q;
		end
		else
		begin
			shift1_q <= {shift1_q[WORD_W-2:0], 1'b0};
			shift2_q <= {shift2_q[WORD_W-2:0], 1'b0};
		end
	end

	// Lane flops, true and complement
	always_ff @(negedge serial_clock)
	begin
		if (!srst_q)
		begin
			channel_one_data_out   <= 1'b0;
			channel_two_data_out   <= 1'b0;
			channel_one_data_out_n <= 1'b1;
			channel_two_data_out_n <= 1'b1;
		end
		else
		begin
			channel_one_data_out   <= load_evt ? word1_q[WORD_W-1] : shift1_q[WORD_W-2];
			channel_two_data_out   <= load_evt ? word2_q[WORD_W-1] : shift2_q[WORD_W-2];
			channel_one_data_out_n <= load_evt ? ~word1_q[WORD_W-1] : ~shift1_q[WORD_W-2];
			channel_two_data_out_n <= load_evt ? ~word2_q[WORD_W-1] : ~shift2_q[WORD_W-2];
		end
	end

	// Echo is the serial clock gated by echo_en_q, not the lane flop path; the complement is not gated
	assign echo_clock_out   = serial_clock & echo_en_q;
	assign echo_clock_out_n = ~serial_clock;

	// Negative pins released in CMOS, driven in LVDS; the echo negative pin only while echo is enabled
	assign channel_one_data_out_n_oe = lvds_q;
	assign channel_two_data_out_n_oe = lvds_q;
	assign echo_clock_out_n_oe       = lvds_q & echo_en_q;

	// ==================================================================
	// Checks, mclk domain
	// ==================================================================
	a_nap_entry: assert property (@(posedge mclk) disable iff (!nrst)
		(pwr_q == dsr_pkg::PWR_OPER && pulses_q == 3'h1 && strb_rise && !sck_evt) |=> pwr_q == dsr_pkg::PWR_NAP)
		else $error("nap not entered on second strobe");
	a_nap_hold: assert property (@(posedge mclk) disable iff (!nrst)
		(pwr_q == dsr_pkg::PWR_NAP && !sck_evt && !strb_rise) |=> pwr_q == dsr_pkg::PWR_NAP)
		else $error("nap left without cause");
	a_nap_wake: assert property (@(posedge mclk) disable iff (!nrst)
		(pwr_q == dsr_pkg::PWR_NAP && sck_evt) |=> pwr_q == dsr_pkg::PWR_OPER ##1 core_powered)
		else $error("serial clock did not wake from nap");
	a_sleep_entry: assert property (@(posedge mclk) disable iff (!nrst)
		(pwr_q == dsr_pkg::PWR_NAP && pulses_q == 3'h3 && strb_rise && !sck_evt)
		|=> pwr_q == dsr_pkg::PWR_SLEEP ##1 !ref_powered)
		else $error("sleep not entered on fourth strobe");
	a_cmos_wake: assert property (@(posedge mclk) disable iff (!nrst)
		(pwr_q == dsr_pkg::PWR_SLEEP && sck_evt && !lvds_q) |=> pwr_q == dsr_pkg::PWR_OPER)
		else $error("cmos serial clock did not wake from sleep");
	a_fifth_wake: assert property (@(posedge mclk) disable iff (!nrst)
		(pwr_q == dsr_pkg::PWR_SLEEP && pulses_q == 3'h4 && strb_rise && !sck_evt)
		|=> pwr_q == dsr_pkg::PWR_OPER && pulses_q == 3'h0)
		else $error("fifth strobe did not wake from sleep");
	a_sck_keeps: assert property (@(posedge mclk) disable iff (!nrst)
		(pwr_q == dsr_pkg::PWR_OPER && sck_evt) |=> pwr_q == dsr_pkg::PWR_OPER && pulses_q <= 3'h1)
		else $error("serial clock did not hold operation");
	a_sample_pulse: assert property (@(posedge mclk) disable iff (!nrst)
		(strb_rise && pwr_q == dsr_pkg::PWR_OPER) |=> sample_start ##1 !sample_start)
		else $error("sampling start not a single pulse");
	a_word_latency: assert property (@(posedge mclk) disable iff (!nrst)
		(strb_fall && pwr_q == dsr_pkg::PWR_OPER) |=> word1_q == $past(conv1_q) && conv2_q == $past(ch2_core_result))
		else $error("result latency wrong");

	// ==================================================================
	// Checks, serial clock domain
	// ==================================================================
	a_msb_first: assert property (@(negedge serial_clock) disable iff (!srst_q)
		load_evt |=> channel_one_data_out == $past(word1_q[WORD_W-1])
		&& channel_two_data_out == $past(word2_q[WORD_W-1]))
		else $error("lanes did not start at msb");
	a_shift_next: assert property (@(negedge serial_clock) disable iff (!srst_q)
		!load_evt |=> channel_one_data_out == $past(shift1_q[WORD_W-2]))
		else $error("lane did not shift next bit");
	a_echo_off: assert property (@(negedge serial_clock) disable iff (!srst_q)
		!echo_en_q |-> !echo_clock_out)
		else $error("echo clock ran while disabled");

	c_nap: cover property (@(posedge mclk) disable iff (!nrst) pwr_q == dsr_pkg::PWR_NAP ##1 pwr_q == dsr_pkg::PWR_OPER);
	c_sleep: cover property (@(posedge mclk) disable iff (!nrst) pwr_q == dsr_pkg::PWR_SLEEP ##1 pwr_q == dsr_pkg::PWR_OPER);
	c_load: cover property (@(negedge serial_clock) disable iff (!srst_q) load_evt ##1 !load_evt);

endmodule

// ### dsr_readout_tb_top.sv
// Purpose: Self-checking bench for the readout and power sequencer
// Assumes: Host model drives strobe and serial clock
// Notes:   Expected words and states follow the one-conversion latency
module dsr_readout_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	// ======================================================================
	// Signals
	// ======================================================================
	logic        mclk = 1'b0;
	logic        nrst;
	logic        lvds_select;
	logic        echo_disable;
	logic [14:0] ch1;
	logic [14:0] ch2;
	logic        sck;
	logic        strobe_n;
	logic        sample_start;
	logic        core_powered;
	logic        ref_powered;
	logic        d1, d1_n, d1_oe, d2, d2_n, d2_oe, eck, eck_n, eck_oe;
	logic [14:0] cap1;
	logic [14:0] cap2;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          ss_cnt = 0;
	int          ec_cnt = 0;

	// 40 MHz system clock
	always #12.5 mclk = ~mclk;

	dsr_readout dut (
		.mclk(mclk), .nrst(nrst), .serial_clock(sck), .conversion_strobe_n(strobe_n),
		.lvds_select(lvds_select), .echo_disable(echo_disable),
		.ch1_core_result(ch1), .ch2_core_result(ch2), .sample_start(sample_start),
		.core_powered(core_powered), .ref_powered(ref_powered),
		.channel_one_data_out(d1), .channel_one_data_out_n(d1_n), .channel_one_data_out_n_oe(d1_oe),
		.channel_two_data_out(d2), .channel_two_data_out_n(d2_n), .channel_two_data_out_n_oe(d2_oe),
		.echo_clock_out(eck), .echo_clock_out_n(eck_n), .echo_clock_out_n_oe(eck_oe)
	);

	dsr_host_model host (
		.mclk(mclk), .serial_clock(sck), .conversion_strobe_n(strobe_n),
		.channel_one_data_out(d1), .channel_two_data_out(d2), .cap1(cap1), .cap2(cap2)
	);

	// Count sample pulses and echo rises
	always @(negedge mclk)
		if (sample_start === 1'b1)
			ss_cnt++;
	always @(posedge eck)
		ec_cnt++;

	// ======================================================================
	// Helpers
	// ======================================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask

	task automatic set_in(input logic l, input logic e);
		@(posedge mclk);
		#2;
		lvds_select = l;
		echo_disable = e;
	endtask

	// Bounded wait for {core_powered, ref_powered}
	task automatic wait_pw(input logic [1:0] e);
		int n;
		n = 0;
		while ({core_powered, ref_powered} !== e && n < 40)
		begin
			@(posedge mclk);
			#2;
			n++;
		end
		chk({core_powered, ref_powered}, e, "power state");
		if ({core_powered, ref_powered} !== e)
			report_and_stop();
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ======================================================================
	// Scenarios
	// ======================================================================
	task automatic t_readout;
		chk({d1_oe, d2_oe, eck_oe}, 0, "cmos oe");
		set_in(1'b0, 1'b0);
		ch1 = 15'h5A3C;
		ch2 = 15'h2C71;
		ss_cnt = 0;
		host.strobe();
		chk(ss_cnt, 1, "sample pulse");
		ec_cnt = 0;
		host.burst(18);
		chk({cap1, cap2}, 0, "stale word");
		chk(ec_cnt, 18, "echo rises");
		ch1 = 15'h0F0F;
		ch2 = 15'h7001;
		host.strobe();
		host.burst(18);
		chk({cap1, cap2}, {15'h5A3C, 15'h2C71}, "words");
		chk(core_powered, 1, "stays up");
		set_in(1'b1, 1'b0);
		host.strobe();
		host.burst(18);
		chk({cap1, cap2}, {15'h0F0F, 15'h7001}, "lvds words");
		set_in(1'b0, 1'b0);
		$display("test readout done");
	endtask

	task automatic t_echo;
		set_in(1'b0, 1'b1);
		host.burst(4);
		ec_cnt = 0;
		host.burst(10);
		chk(ec_cnt, 0, "echo off");
		set_in(1'b0, 1'b0);
		host.burst(4);
		$display("test echo done");
	endtask

	task automatic t_nap;
		host.strobe();
		chk(core_powered, 1, "one pulse");
		host.strobe();
		wait_pw(2'b01);
		host.burst(1);
		wait_pw(2'b11);
		$display("test nap done");
	endtask

	task automatic t_sleep_cmos;
		host.strobe();
		host.strobe();
		wait_pw(2'b01);
		ss_cnt = 0;
		host.strobe();
		chk({core_powered, ref_powered}, 2'b01, "nap holds");
		chk(ss_cnt, 0, "no sample");
		host.strobe();
		wait_pw(2'b00);
		host.burst(1);
		wait_pw(2'b11);
		$display("test sleep cmos done");
	endtask

	task automatic t_sleep_lvds;
		set_in(1'b1, 1'b0);
		repeat (4) @(posedge mclk);
		#2;
		chk({d1_oe, d2_oe, eck_oe}, 3'b111, "lvds oe");
		host.burst(18);
		chk({d1, d1_n, d2, d2_n}, 4'b0101, "pairs");
		chk({eck, eck_n}, 2'b01, "echo pair");
		repeat (4) host.strobe();
		wait_pw(2'b00);
		host.strobe();
		wait_pw(2'b11);
		host.strobe();
		host.strobe();
		wait_pw(2'b01);
		host.burst(1);
		wait_pw(2'b11);
		repeat (4) host.strobe();
		wait_pw(2'b00);
		host.burst(1);
		repeat (8) @(posedge mclk);
		#2;
		chk({core_powered, ref_powered}, 2'b00, "lvds sleep holds");
		repeat (5) host.strobe();
		wait_pw(2'b11);
		set_in(1'b0, 1'b0);
		$display("test sleep lvds done");
	endtask

	// ======================================================================
	// Main sequence
	// ======================================================================
	initial
	begin
		nrst = 1'b0;
		lvds_select = 1'b0;
		echo_disable = 1'b0;
		ch1 = 15'h0000;
		ch2 = 15'h0000;
		host.burst(6);
		repeat (6) @(posedge mclk);
		#2;
		nrst = 1'b1;
		repeat (3) @(posedge mclk);
		host.burst(6);
		t_readout();
		t_echo();
		t_nap();
		t_sleep_cmos();
		t_sleep_lvds();
		report_and_stop();
	end

	// Hang guard
	initial
	begin
		#100us;
		error_cnt++;
		$display("BAD %0t hang", $time);
		report_and_stop();
	end
endmodule
